/* pwm_autoshutdown_gate_ctrl.sv */
// Auto-shutdown and gating control top with AHB-Lite register slave.
// Assumes one clock; period_start marks time-base reset or rollover.
//
// Summary of operation
// - Restart enable auto-clears flag at next period start if no request is active
// - Gate mode defers shutdown to period boundary
// - Software force acts as a shutdown event
// - Eight source enable bits gate shutdown sources
`timescale 1ns/100ps
module pwm_autoshutdown_gate_ctrl (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer unit
  input  wire logic [7:0]  shutdown_sources,
  input  wire logic        period_start,
  output logic             shutdown_event_flag,
  output logic             shutdown_active,
  // Interrupt
  output logic             irq
);

  logic [15:0]                 ctrl;
  logic [15:0]                 next_ctrl;
  logic [1:0]                  irq_status;
  logic [1:0]                  next_irq_status;
  logic [1:0]                  irq_mask;
  logic [1:0]                  next_irq_mask;
  shutdown_gate_pkg::bus_req_t req;
  shutdown_gate_pkg::bus_req_t next_req;
  logic                        req_valid;
  logic                        next_req_valid;
  logic [31:0]                 next_hrdata;
  logic                        soft_clear;
  logic                        set_pulse;
  logic                        clear_pulse;
  shutdown_gate_pkg::control_t control;

  ////////////////////////////////////////////////////////////////////////
  // Bus capture: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    next_req_valid = hsel && hready && (htrans == shutdown_gate_pkg::htrans_nonseq);
    next_req.addr  = haddr;
    next_req.write = hwrite;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else begin
      req_valid <= next_req_valid;
      req       <= next_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes in the data phase
  always_comb begin
    next_ctrl       = ctrl;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    soft_clear      = 1'b0;
    if (req_valid && req.write) begin
      unique case (req.addr)
        shutdown_gate_pkg::ctrl_addr:
          next_ctrl = hwdata[15:0] & shutdown_gate_pkg::ctrl_write_mask;
        shutdown_gate_pkg::status_addr:
          soft_clear = ~hwdata[0]; // Writing zero clears the flag unless restart is enabled
        shutdown_gate_pkg::irq_status_addr:
          next_irq_status = irq_status & ~hwdata[1:0];
        shutdown_gate_pkg::irq_mask_addr:
          next_irq_mask = hwdata[1:0];
        default: ;
      endcase
    end
    // Hardware set wins over write-one-to-clear
    next_irq_status[shutdown_gate_pkg::irq_event_set]   =
      next_irq_status[shutdown_gate_pkg::irq_event_set] | set_pulse;
    next_irq_status[shutdown_gate_pkg::irq_event_clear] =
      next_irq_status[shutdown_gate_pkg::irq_event_clear] | clear_pulse;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl       <= shutdown_gate_pkg::ctrl_reset;
      irq_status <= shutdown_gate_pkg::irq_reset;
      irq_mask   <= shutdown_gate_pkg::irq_reset;
    end else begin
      ctrl       <= next_ctrl;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data registered one cycle after the address phase
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_req_valid && !hwrite) begin
      unique case (haddr)
        shutdown_gate_pkg::ctrl_addr:       next_hrdata = {16'h0000, next_ctrl};
        shutdown_gate_pkg::status_addr:     next_hrdata = {31'h0, shutdown_event_flag};
        shutdown_gate_pkg::irq_status_addr: next_hrdata = {30'h0, next_irq_status};
        shutdown_gate_pkg::irq_mask_addr:   next_hrdata = {30'h0, next_irq_mask};
        default:                            next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control fields feed the event core
  assign control.restart_enable = ctrl[shutdown_gate_pkg::restart_bit];
  assign control.gate_mode      = ctrl[shutdown_gate_pkg::gate_mode_bit];
  assign control.force_shutdown = ctrl[shutdown_gate_pkg::force_bit];
  assign control.source_enable  = ctrl[7:0];

  shutdown_event_core core (
    .clock               (clock),
    .reset               (reset),
    .control             (control),
    .shutdown_sources    (shutdown_sources),
    .period_start        (period_start),
    .soft_clear          (soft_clear),
    .shutdown_event_flag (shutdown_event_flag),
    .shutdown_request    (shutdown_active),
    .event_set_pulse     (set_pulse),
    .event_clear_pulse   (clear_pulse)
  );

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irq_status & irq_mask);

endmodule : pwm_autoshutdown_gate_ctrl

/* pwm_autoshutdown_gate_ctrl_tb_top.sv */
// Self-checking bench for the shutdown gate control block.
// Assumes a zero-wait bus slave and the sg_src source model.
`timescale 1ns/100ps
module pwm_autoshutdown_gate_ctrl_tb_top;
  logic clock, reset, hsel, hwrite, hready, hreadyout, hresp, period_start, shutdown_event_flag, shutdown_active, irq;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [7:0]  level, shutdown_sources;
  int          bad_count, checked, cycles;
  assign hready = hreadyout;
  pwm_autoshutdown_gate_ctrl uut (.clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .shutdown_sources, .period_start, .shutdown_event_flag, .shutdown_active, .irq);
  sg_src src_i (.clock, .reset, .level, .shutdown_sources, .period_start);
  ////////////////////////////////////////////////////////////////////////
  // Clock and a ceiling well above the run length
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Single word transfer; the master waits on hready, never on a count
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(n, q, e);
  endtask : rdchk
  task automatic wait_period();
    do @(posedge clock); while (period_start !== 1'b1);
  endtask : wait_period
  task automatic finish_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, hsel, hwrite, haddr, htrans, hsize, hwdata, level} = {1'b1, 16'h0, 3'h2, 40'h0};
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rdchk("reset", 12'(i * 4), 32'h0);
    chk("ready okay", {30'h0, hreadyout, hresp}, 32'h2);
    $display("test reset done");
    // Force under gate mode waits for the period boundary
    bus(1'b1, 12'h000, 32'hffffffff);
    rdchk("ctrl", 12'h000, 32'h0000d0ff);
    wait_period();
    @(posedge clock);
    chk("forced", shutdown_event_flag, 1);
    bus(1'b1, 12'h000, 32'h00008000);
    wait_period();
    @(posedge clock);
    chk("restart", shutdown_event_flag, 0);
    bus(1'b1, 12'h00c, 32'h2);
    @(posedge clock);
    chk("irq on", irq, 1);
    bus(1'b1, 12'h008, 32'h3);
    @(posedge clock);
    chk("irq off", irq, 0);
    $display("test force done");
    // Each source alone: others active but disabled, then sticky without restart
    for (int n = 0; n < 8; n++) begin
      bus(1'b1, 12'h000, 32'(1 << n));
      level <= ~(8'h01 << n);
      repeat (3) @(posedge clock);
      chk("masked", shutdown_event_flag, 0);
      level <= 8'h01 << n;
      repeat (2) @(posedge clock);
      chk("source", shutdown_event_flag, 1);
      level <= 8'h00;
      wait_period();
      @(posedge clock);
      chk("sticky", shutdown_event_flag, 1);
      bus(1'b1, 12'h004, 32'h0);
      // Status read returns the flag as it stood, so let the clear settle first
      @(posedge clock);
      rdchk("cleared", 12'h004, 32'h0);
    end
    $display("test sources done");
    // Gate mode defers a source event
    bus(1'b1, 12'h000, 32'h00004001);
    wait_period();
    level <= 8'h01;
    repeat (2) @(posedge clock);
    chk("deferred", shutdown_event_flag, 0);
    wait_period();
    @(posedge clock);
    chk("boundary", shutdown_active, 1);
    $display("test gate mode done");
    finish_test();
  end
endmodule : pwm_autoshutdown_gate_ctrl_tb_top

/* sg_chk.sv */
// Assertion checker for the shutdown gate control top.
// Assumes it is bound to that top; control is shadowed from bus writes.
`timescale 1ns/100ps
module sg_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Register bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Timer side
  input wire logic [7:0]  shutdown_sources,
  input wire logic        period_start,
  input wire logic        shutdown_event_flag
);
  logic [15:0] ctl, next_ctl;
  logic [11:0] pa;
  logic        pw, pr, req;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // Shadow: a write lands at the end of its data phase
  always_comb begin
    next_ctl = (pw && pa == shutdown_gate_pkg::ctrl_addr) ? hwdata[15:0] & shutdown_gate_pkg::ctrl_write_mask : ctl;
    req = |(shutdown_sources & ctl[7:0]) || ctl[12];
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl <= 16'h0000;
      pw  <= 1'b0;
      pr  <= 1'b0;
    end else begin
      ctl <= next_ctl;
      pw  <= hsel && hready && htrans == 2'h2 && hwrite;
      pr  <= hsel && hready && htrans == 2'h2 && !hwrite;
    end
  end
  always_ff @(posedge clock) pa <= haddr;
  ////////////////////////////////////////////////////////////////////////
  property p_set; req && (!ctl[14] || period_start) |=> shutdown_event_flag; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_defer; ctl[14] && !shutdown_event_flag && !period_start |=> !shutdown_event_flag; endproperty
  a_defer: assert property (p_defer) else $error("flag set early");
  property p_restart; shutdown_event_flag && ctl[15] && period_start && !req |=> !shutdown_event_flag; endproperty
  a_restart: assert property (p_restart) else $error("flag not cleared");
  property p_sticky; shutdown_event_flag && !ctl[15] && !(pw && pa == 12'h004) |=> shutdown_event_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_read; pr && pa == shutdown_gate_pkg::ctrl_addr |-> hrdata == {16'h0000, ctl}; endproperty
  a_read: assert property (p_read) else $error("control readback");
  c_defer: cover property (req && ctl[14] && period_start);
  c_restart: cover property (shutdown_event_flag && ctl[15] && period_start && !req);
  c_read: cover property (pr && pa == shutdown_gate_pkg::ctrl_addr);
endmodule : sg_chk
bind pwm_autoshutdown_gate_ctrl sg_chk chk_i (.clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .shutdown_sources, .period_start, .shutdown_event_flag);

/* sg_src.sv */
// Source and period model standing beside the shutdown gate block.
// Assumes the bench sets source levels; one period start each period_len.
`timescale 1ns/100ps
module sg_src #(parameter int period_len = 16) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // Levels chosen by the bench
  input wire logic [7:0] level,
  // To the block
  output logic [7:0]     shutdown_sources,
  output logic           period_start
);
  logic [7:0] cnt;
  // Sources are plain levels; period start is one clock wide
  assign shutdown_sources = level;
  assign period_start = cnt == 8'(period_len - 1);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) cnt <= 8'h00;
    else cnt <= period_start ? 8'h00 : cnt + 8'h01;
  end
endmodule : sg_src

/* shutdown_event_core.sv */
// Shutdown event latch: applies gate mode timing and restart policy.
// Assumes period_start and sources are synchronous to clock.
`timescale 1ns/100ps
module shutdown_event_core (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // Configuration
  input  wire shutdown_gate_pkg::control_t control,
  input  wire logic [7:0]                  shutdown_sources,
  input  wire logic                        period_start,
  input  wire logic                        soft_clear,
  // Results
  output logic                             shutdown_event_flag,
  output logic                             shutdown_request,
  output logic                             event_set_pulse,
  output logic                             event_clear_pulse
);

  logic next_flag;
  logic active_request;

  // Any enabled source or software force is a shutdown request
  assign active_request = (|(shutdown_sources & control.source_enable))
                          | control.force_shutdown;

  ////////////////////////////////////////////////////////////////////////
  // Next flag: setting wins over clearing so no event is lost
  always_comb begin
    next_flag = shutdown_event_flag;
    if (soft_clear && !control.restart_enable) begin
      next_flag = 1'b0;
    end
    if (control.restart_enable && period_start && !active_request) begin
      next_flag = 1'b0;
    end
    if (active_request && (!control.gate_mode || period_start)) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shutdown_event_flag <= 1'b0;
      event_set_pulse     <= 1'b0;
      event_clear_pulse   <= 1'b0;
    end else begin
      shutdown_event_flag <= next_flag;
      event_set_pulse     <= next_flag & ~shutdown_event_flag;
      event_clear_pulse   <= ~next_flag & shutdown_event_flag;
    end
  end

  // Latched event flag drives the timer gate path, so gate mode defers it
  assign shutdown_request = shutdown_event_flag;

endmodule : shutdown_event_core

/* shutdown_gate_pkg.sv */
// Package for the auto-shutdown and gating control block.
// Assumes a single 125 MHz clock and an AHB-Lite register port.
package shutdown_gate_pkg;

  // Register map (byte addresses)
  localparam logic [11:0] ctrl_addr      = 12'h000;
  localparam logic [11:0] status_addr    = 12'h004;
  localparam logic [11:0] irq_status_addr = 12'h008;
  localparam logic [11:0] irq_mask_addr  = 12'h00c;

  // Control field positions
  localparam int restart_bit  = 15;
  localparam int gate_mode_bit = 14;
  localparam int force_bit    = 12;
  localparam logic [15:0] ctrl_write_mask = 16'hd0ff;
  localparam logic [15:0] ctrl_reset      = 16'h0000;

  // Interrupt status bits
  localparam int irq_event_set   = 0;
  localparam int irq_event_clear = 1;
  localparam logic [1:0] irq_reset = 2'h0;

  // AHB encodings
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word    = 3'h2;

  typedef struct packed {
    logic       restart_enable;
    logic       gate_mode;
    logic       force_shutdown;
    logic [7:0] source_enable;
  } control_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
  } bus_req_t;

endpackage : shutdown_gate_pkg
